// File: rtl/cpu_status_flags_map.svh
`ifndef CPU_STATUS_FLAGS_MAP_SVH
`define CPU_STATUS_FLAGS_MAP_SVH
// What this block does
// - condition register accepts any instruction as destination
// - flag-updating ops override written flag bits
// - expiry and doze bits ignore software writes
// - zeroing op: upper three cleared, zero set
// - bank bit selects 80h-FFh or 00h-7Fh
// - expiry set by power-up/kick/doze, cleared timeout
// - doze bit set power-up/kick, cleared by doze
// - zero flag follows result equal zero
// - nibble carry from bit 3 on add/sub
// - carry from bit 7 on add/sub
// - rotates load carry from shifted-out bit
// - watchdog off only by config, own tick
// - oscillator settle timer holds core in reset
// - supply settle delay only at power-up
// - wake from doze: ext reset, watchdog, interrupt

// ==========================================================
// register offsets
`define CF_OFFS_FLAGS 8'h00
`define CF_OFFS_WD_LIMIT 8'h04
`define CF_OFFS_STATE 8'h08

// ==========================================================
// field positions and reset values
`define CF_BIT_BANK 5
`define CF_BIT_EXPIRY 4
`define CF_BIT_DOZE 3
`define CF_FLAGS_POR 8'h18
`define CF_WD_LIMIT_RST 16'h0010
`define CF_RESP_OKAY 2'b00
`define CF_RESP_SLVERR 2'b10

// ==========================================================
// timing
`define CF_CLK_NS 8
`define CF_SUPPLY_SETTLE_NS 2000
`define CF_SUPPLY_SETTLE_CYC ((`CF_SUPPLY_SETTLE_NS + `CF_CLK_NS - 1) / `CF_CLK_NS)
`define CF_OSC_SETTLE_CYC 1024
`define CF_WD_TICK_NS 800
`define CF_WD_TICK_CYC (`CF_WD_TICK_NS / `CF_CLK_NS)
`endif

// File: rtl/cpu_status_flags_pkg.sv
package cpu_status_flags_pkg;
  typedef enum logic [3:0] {
    no_op = 4'h0,
    alu_add = 4'h1,
    alu_sub = 4'h2,
    alu_logic = 4'h3,
    rotate_right_op = 4'h4,
    rotate_left_op = 4'h5,
    file_zeroing_op = 4'h6,
    move_op = 4'h7,
    watchdog_kick_op = 4'h8,
    doze_op = 4'h9
  } op_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic dest_cond;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] data;
  } exec_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } exec_res_t;

  typedef struct packed {
    logic indirect_bank_bit;
    logic upper_bank_bit;
    logic bank_sel_bit;
    logic watchdog_expiry_flag;
    logic doze_entry_flag;
    logic zero_flag;
    logic nibble_overflow_bit;
    logic carry_flag;
  } flags_t;

  typedef enum logic [1:0] {
    ph_supply = 2'b00,
    ph_osc = 2'b01,
    ph_run = 2'b10,
    ph_doze = 2'b11
  } phase_t;
endpackage

// File: rtl/wait_counter.sv
`timescale 1ns/100ps
module wait_counter #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } wc_state_t;

  wc_state_t s_q;
  wc_state_t s_d;

  assign done = (s_q.cnt >= limit);

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = '0;
    end else if (tick && !done) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // wait_counter

// File: rtl/cpu_status_flags.sv
`timescale 1ns/100ps
`include "cpu_status_flags_map.svh"
module cpu_status_flags #(
  parameter int SUPPLY_CYC = `CF_SUPPLY_SETTLE_CYC,
  parameter int OSC_CYC = `CF_OSC_SETTLE_CYC,
  parameter int WD_TICK_CYC = `CF_WD_TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire cpu_status_flags_pkg::exec_req_t exec_i,
  output cpu_status_flags_pkg::exec_res_t res_o,
  output cpu_status_flags_pkg::flags_t flags_o,
  input wire logic [6:0] file_addr,
  output logic [7:0] data_addr,
  input wire logic ext_reset_n_pin,
  input wire logic wd_cfg_en_pin,
  input wire logic wake_irq,
  output logic core_hold,
  output logic core_dozing
);
  import cpu_status_flags_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    phase_t phase;
    flags_t flags;
    logic [2:0] rst_sync;
    logic [2:0] cfg_sync;
    logic ext_lvl;
    logic cfg_lvl;
    logic [15:0] wd_limit;
    logic [15:0] wd_div;
    exec_res_t res;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic supply_done;
  logic osc_done;
  logic wd_done;
  logic wd_tick;
  logic wd_clr;
  logic exec_fire;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_nib;
  logic [2:0] aff;
  logic [7:0] b_op;
  logic [8:0] sum9;
  logic [4:0] sum5;

  // ==========================================================
  // bus handshakes and outputs
  assign awready = !s_q.aw_have && !s_q.bvalid;
  assign wready = !s_q.w_have && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign res_o = s_q.res;
  assign flags_o = s_q.flags;
  assign data_addr = {s_q.flags.bank_sel_bit, file_addr};
  assign core_hold = (s_q.phase == ph_supply) || (s_q.phase == ph_osc);
  assign core_dozing = (s_q.phase == ph_doze);
  assign exec_fire = exec_i.valid && (s_q.phase == ph_run);
  assign wd_tick = (s_q.wd_div == 16'h0000);
  // the divider stands in for the private oscillator; runtime code cannot stop it
  // a watchdog wake restarts the count, else the core would be reset one cycle later
  assign wd_clr = !s_q.cfg_lvl || core_hold || (core_dozing && wd_done)
    || (exec_fire && (exec_i.op == watchdog_kick_op || exec_i.op == doze_op));

  // ==========================================================
  // timers
  wait_counter #(.W(16)) u_supply (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(s_q.phase != ph_supply),
    .tick(1'b1),
    .limit(16'(SUPPLY_CYC)),
    .done(supply_done)
  );

  wait_counter #(.W(16)) u_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(s_q.phase != ph_osc || !s_q.ext_lvl),
    .tick(1'b1),
    .limit(16'(OSC_CYC)),
    .done(osc_done)
  );

  wait_counter #(.W(16)) u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(wd_clr),
    .tick(wd_tick),
    .limit(s_q.wd_limit),
    .done(wd_done)
  );

  // ==========================================================
  // arithmetic
  always_comb begin
    b_op = (exec_i.op == alu_sub) ? ~exec_i.b : exec_i.b;
    sum9 = {1'b0, exec_i.a} + {1'b0, b_op} + {8'h00, exec_i.op == alu_sub};
    sum5 = {1'b0, exec_i.a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, exec_i.op == alu_sub};
    alu_res = exec_i.data;
    alu_c = s_q.flags.carry_flag;
    alu_nib = sum5[4];
    aff = 3'b000;
    case (exec_i.op)
      alu_add, alu_sub: begin
        alu_res = sum9[7:0];
        alu_c = sum9[8];
        aff = 3'b111;
      end
      alu_logic: begin
        aff = 3'b100;
      end
      rotate_right_op: begin
        alu_res = {s_q.flags.carry_flag, exec_i.a[7:1]};
        alu_c = exec_i.a[0];
        aff = 3'b001;
      end
      rotate_left_op: begin
        alu_res = {exec_i.a[6:0], s_q.flags.carry_flag};
        alu_c = exec_i.a[7];
        aff = 3'b001;
      end
      file_zeroing_op: begin
        alu_res = 8'h00;
        aff = 3'b100;
      end
      default: begin
        aff = 3'b000;
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.res.valid = 1'b0;
    // only the second and third stages are compared; the first feeds the second alone
    s_d.rst_sync = {s_q.rst_sync[1:0], ext_reset_n_pin};
    s_d.cfg_sync = {s_q.cfg_sync[1:0], wd_cfg_en_pin};
    if (s_q.rst_sync[2] == s_q.rst_sync[1]) begin
      s_d.ext_lvl = s_q.rst_sync[2];
    end
    if (s_q.cfg_sync[2] == s_q.cfg_sync[1]) begin
      s_d.cfg_lvl = s_q.cfg_sync[2];
    end
    s_d.wd_div = wd_tick ? 16'(WD_TICK_CYC - 1) : s_q.wd_div - 16'h0001;

    // software side: bus writes to the condition register act as a plain move
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CF_RESP_OKAY;
      case (s_q.aw_addr)
        `CF_OFFS_FLAGS: begin
          if (s_q.w_strb[0]) begin
            s_d.flags = s_q.w_data[7:0];
            s_d.flags.watchdog_expiry_flag = s_q.flags.watchdog_expiry_flag;
            s_d.flags.doze_entry_flag = s_q.flags.doze_entry_flag;
          end
        end
        `CF_OFFS_WD_LIMIT: begin
          if (s_q.w_strb[0]) begin
            s_d.wd_limit[7:0] = s_q.w_data[7:0];
          end
          if (s_q.w_strb[1]) begin
            s_d.wd_limit[15:8] = s_q.w_data[15:8];
          end
          if (s_d.wd_limit == 16'h0000) begin
            s_d.wd_limit = 16'h0001;
          end
        end
        `CF_OFFS_STATE: begin
          s_d.bresp = `CF_RESP_OKAY;
        end
        default: begin
          s_d.bresp = `CF_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `CF_RESP_OKAY;
      case (araddr)
        `CF_OFFS_FLAGS: s_d.rdata = {24'h000000, s_q.flags};
        `CF_OFFS_WD_LIMIT: s_d.rdata = {16'h0000, s_q.wd_limit};
        `CF_OFFS_STATE: s_d.rdata = {28'h0000000, s_q.cfg_lvl, s_q.ext_lvl, s_q.phase};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = `CF_RESP_SLVERR;
        end
      endcase
    end

    // core side: an instruction wins over a bus write in the same cycle
    if (exec_fire) begin
      case (exec_i.op)
        watchdog_kick_op: begin
          s_d.flags.watchdog_expiry_flag = 1'b1;
          s_d.flags.doze_entry_flag = 1'b1;
        end
        doze_op: begin
          s_d.flags.watchdog_expiry_flag = 1'b1;
          s_d.flags.doze_entry_flag = 1'b0;
          s_d.phase = ph_doze;
        end
        no_op: begin
          s_d.res.valid = 1'b0;
        end
        default: begin
          s_d.res.valid = 1'b1;
          s_d.res.data = alu_res;
          // a flag-updating op blocks the written value for all three low flags
          if (exec_i.dest_cond) begin
            s_d.flags = {alu_res[7:5], s_q.flags.watchdog_expiry_flag,
              s_q.flags.doze_entry_flag,
              (aff != 3'b000) ? s_q.flags[2:0] : alu_res[2:0]};
          end
          if (aff[2]) begin
            s_d.flags.zero_flag = (alu_res == 8'h00);
          end
          if (aff[1]) begin
            s_d.flags.nibble_overflow_bit = alu_nib;
          end
          if (aff[0]) begin
            s_d.flags.carry_flag = alu_c;
          end
        end
      endcase
    end

    // reset timing and doze exits
    case (s_q.phase)
      ph_supply: begin
        if (supply_done) begin
          s_d.phase = ph_osc;
        end
      end
      ph_osc: begin
        if (osc_done && s_q.ext_lvl) begin
          s_d.phase = ph_run;
        end
      end
      ph_run: begin
        if (wd_done && !exec_fire) begin
          s_d.flags.watchdog_expiry_flag = 1'b0;
          s_d.flags.bank_sel_bit = 1'b0;
          s_d.flags.indirect_bank_bit = 1'b0;
          s_d.flags.upper_bank_bit = 1'b0;
          s_d.phase = ph_osc;
        end
      end
      ph_doze: begin
        if (wd_done) begin
          s_d.flags.watchdog_expiry_flag = 1'b0;
          s_d.phase = ph_run;
        end else if (wake_irq) begin
          s_d.phase = ph_run;
        end
      end
      default: begin
        s_d.phase = ph_supply;
      end
    endcase
    if (!s_q.ext_lvl && s_q.phase != ph_supply) begin
      s_d.flags.bank_sel_bit = 1'b0;
      s_d.flags.indirect_bank_bit = 1'b0;
      s_d.flags.upper_bank_bit = 1'b0;
      s_d.phase = ph_osc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.phase <= ph_supply;
      s_q.flags <= `CF_FLAGS_POR;
      s_q.rst_sync <= 3'b111;
      s_q.cfg_sync <= 3'b111;
      s_q.ext_lvl <= 1'b1;
      s_q.cfg_lvl <= 1'b1;
      s_q.wd_limit <= `CF_WD_LIMIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // checks
  property p_sw_keeps_cause;
    @(posedge aclk) disable iff (!aresetn)
    (s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.aw_addr == `CF_OFFS_FLAGS && !exec_fire
      && s_q.phase == ph_run && !wd_done && s_q.ext_lvl)
    |=> $stable(s_q.flags[4:3]);
  endproperty
  a_sw_keeps_cause: assert property (p_sw_keeps_cause) else $error("cause bits written");

  property p_zeroing_cond;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == file_zeroing_op && exec_i.dest_cond && !wd_done && s_q.ext_lvl)
    |=> (s_q.flags[7:5] == 3'b000) && s_q.flags.zero_flag && $stable(s_q.flags[1:0]);
  endproperty
  a_zeroing_cond: assert property (p_zeroing_cond) else $error("zeroing op wrong");

  property p_doze_entry;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == doze_op && s_q.ext_lvl)
    |=> !s_q.flags.doze_entry_flag && s_q.flags.watchdog_expiry_flag && core_dozing;
  endproperty
  a_doze_entry: assert property (p_doze_entry) else $error("doze entry wrong");

  property p_kick;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == watchdog_kick_op && s_q.ext_lvl)
    |=> s_q.flags.watchdog_expiry_flag && s_q.flags.doze_entry_flag;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not set bits");

  property p_zero_flag;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == alu_logic && !wd_done && s_q.ext_lvl)
    |=> s_q.flags.zero_flag == ($past(exec_i.data) == 8'h00) && s_q.res.valid;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_sub_borrow;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == alu_sub && !wd_done && s_q.ext_lvl)
    |=> s_q.flags.carry_flag == ($past(exec_i.a) >= $past(exec_i.b))
      && s_q.flags.nibble_overflow_bit == ($past(exec_i.a[3:0]) >= $past(exec_i.b[3:0]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow wrong");

  property p_rot_right;
    @(posedge aclk) disable iff (!aresetn)
    (exec_fire && exec_i.op == rotate_right_op && !wd_done && s_q.ext_lvl)
    |=> s_q.flags.carry_flag == $past(exec_i.a[0]);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate carry wrong");

  property p_wd_off;
    @(posedge aclk) disable iff (!aresetn)
    (!s_q.cfg_lvl) [*2] |-> !wd_done;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog ran while off");

  property p_wd_wake;
    @(posedge aclk) disable iff (!aresetn)
    (core_dozing && wd_done && s_q.ext_lvl) |=> (s_q.phase == ph_run) && !s_q.flags[4];
  endproperty
  a_wd_wake: assert property (p_wd_wake) else $error("watchdog wake wrong");

  property p_hold_in_osc;
    @(posedge aclk) disable iff (!aresetn)
    (s_q.phase == ph_osc && !osc_done) |=> core_hold;
  endproperty
  a_hold_in_osc: assert property (p_hold_in_osc) else $error("core released early");

  c_irq_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    core_dozing && wake_irq ##1 s_q.phase == ph_run);
  c_wd_reset: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.phase == ph_run && wd_done ##1 s_q.phase == ph_osc);
  c_zeroing: cover property (@(posedge aclk) disable iff (!aresetn)
    exec_fire && exec_i.op == file_zeroing_op && exec_i.dest_cond);
endmodule // cpu_status_flags

// File: sim/exec_unit_model.sv
`timescale 1ns/100ps
// ==========================================================
// instruction issue side: one op per call, held until the next call
module exec_unit_model (
  input wire logic aclk,
  output cpu_status_flags_pkg::exec_req_t exec_req,
  output logic [6:0] file_addr
);
  import cpu_status_flags_pkg::*;
  initial exec_req = '0;
  initial file_addr = '0;
  task automatic issue(input op_t op, input logic d, input logic [7:0] a, b, x,
                       input logic [6:0] fa);
    exec_req <= {1'b1, op, d, a, b, x};
    file_addr <= fa;
    @(posedge aclk);
  endtask
  // idle operands flip so stale values never look valid
  task automatic idle();
    exec_req <= {1'b0, no_op, 1'b0, ~exec_req.a, ~exec_req.b, ~exec_req.data};
    @(posedge aclk);
  endtask
endmodule // exec_unit_model

// File: sim/cpu_status_flags_bench.sv
`timescale 1ns/100ps
module cpu_status_flags_bench;
  import cpu_status_flags_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, core_hold, core_dozing;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  exec_req_t exec_req;
  exec_res_t res;
  flags_t flags;
  logic [6:0] file_addr;
  logic [7:0] data_addr, ref_f;
  logic wd_en = 0, wake_irq = 0, ext_n = 1;
  logic [15:0] exp_q[$];
  int fails = 0, n_tests = 0, i;
  always #4 aclk = ~aclk;
  // short counts keep the run brief
  cpu_status_flags #(.SUPPLY_CYC(4), .OSC_CYC(4), .WD_TICK_CYC(2)) cpu_status_flags_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .exec_i(exec_req),
    .res_o(res), .flags_o(flags), .file_addr(file_addr), .data_addr(data_addr),
    .ext_reset_n_pin(ext_n), .wd_cfg_en_pin(wd_en), .wake_irq(wake_irq),
    .core_hold(core_hold), .core_dozing(core_dozing));
  exec_unit_model exec_unit_model_inst (.aclk(aclk), .exec_req(exec_req), .file_addr(file_addr));
  // ==========================================================
  // checking
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge aclk) begin
    if (aresetn === 1'b1) begin
      check("data_addr", data_addr, (flags[5] ? 8'h80 : 8'h00) | {1'b0, file_addr});
    end
    if (res.valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra result", 1, 0);
      else begin
        check("result", res.data, exp_q[0][15:8]);
        check("flags", flags, exp_q[0][7:0]);
        void'(exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    close_out();
  end
  // ==========================================================
  // reference flag behaviour: returns {result, flags}
  function automatic logic [15:0] predict(input op_t op, input logic d,
                                          input logic [7:0] a, b, x, f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r, m, n;
    n = f;
    m = 8'h00;
    r = x;
    s = '0;
    h = '0;
    case (op)
      alu_add, alu_sub: begin
        s = {1'b0, a} + {1'b0, (op == alu_sub) ? ~b : b} + {8'h00, op == alu_sub};
        h = {1'b0, a[3:0]} + {1'b0, (op == alu_sub) ? ~b[3:0] : b[3:0]} + {4'h0, op == alu_sub};
        r = s[7:0];
        n[2:0] = {r == 8'h00, h[4], s[8]};
        m = 8'h07;
      end
      // any flag-updating op blocks the write to all three low flags
      alu_logic: begin
        n[2] = (x == 8'h00);
        m = 8'h07;
      end
      rotate_right_op: begin
        r = {f[0], a[7:1]};
        n[0] = a[0];
        m = 8'h07;
      end
      rotate_left_op: begin
        r = {a[6:0], f[0]};
        n[0] = a[7];
        m = 8'h07;
      end
      file_zeroing_op: begin
        r = 8'h00;
        n[2] = 1'b1;
        m = 8'h07;
      end
      default: ;
    endcase
    if (d) n = (r & ~m & 8'hE7) | (n & m) | (f & 8'h18);
    return {r, n};
  endfunction
  task automatic ex(input op_t op, input logic d, input logic [7:0] a, b, x);
    logic [15:0] e;
    e = predict(op, d, a, b, x, ref_f);
    exp_q.push_back(e);
    ref_f = e[7:0];
    exec_unit_model_inst.issue(op, d, a, b, x, 7'($urandom));
  endtask
  // ==========================================================
  // register bus master
  task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    hb = 0;
    n = 0;
    while (!hb && n < 50) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      if (hb) check("bresp", bresp, er);
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
      n++;
    end
    bready <= 0;
    if (!hb) check("write answer", 0, 1);
  endtask
  task automatic axi_read(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ha, hr;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    hr = 0;
    n = 0;
    while (!hr && n < 50) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      if (hr) check("rdata", rdata, ed);
      if (hr) check("rresp", rresp, er);
      @(posedge aclk);
      if (ha) arvalid <= 0;
      n++;
    end
    rready <= 0;
    if (!hr) check("read answer", 0, 1);
  endtask
  task automatic settle();
    exec_unit_model_inst.idle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("pending results", exp_q.size(), 0);
  endtask
  task automatic wait_hold(input logic lvl);
    int n;
    n = 0;
    while (core_hold !== lvl && n < 400) begin
      @(negedge aclk);
      n++;
    end
    check("core_hold", core_hold, lvl);
    @(posedge aclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h5894));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    check("por flags", flags, 8'h18);
    check("held", core_hold, 1);
    axi_read(8'h00, 32'h18, 2'b00);
    wait_hold(1'b0);
    ref_f = 8'h18;
    axi_write(8'h00, 32'h00, 4'h1, 2'b00);
    axi_read(8'h00, 32'h18, 2'b00);
    axi_write(8'h00, 32'h27, 4'h1, 2'b00);
    axi_read(8'h00, 32'h3F, 2'b00);
    ref_f = 8'h3F;
    axi_read(8'h0C, 32'h0, 2'b10);
    axi_write(8'h08, 32'hF, 4'hF, 2'b00);
    ex(alu_add, 0, 8'hF8, 8'h08, 8'h00);
    ex(alu_add, 0, 8'h7F, 8'h01, 8'h00);
    ex(alu_sub, 0, 8'h05, 8'h06, 8'h00);
    ex(alu_sub, 1, 8'h05, 8'h05, 8'h00);
    ex(alu_add, 1, 8'h10, 8'h05, 8'h00);
    ex(rotate_right_op, 0, 8'h81, 8'h00, 8'h00);
    ex(rotate_left_op, 0, 8'h40, 8'h00, 8'h00);
    ex(rotate_right_op, 1, 8'h01, 8'h00, 8'h00);
    ex(alu_logic, 0, 8'h00, 8'h00, 8'h00);
    ex(move_op, 1, 8'h00, 8'h00, 8'h3C);
    ex(file_zeroing_op, 1, 8'h00, 8'h00, 8'h00);
    for (i = 0; i < 80; i++) begin
      // move and logic data carry only the low six bits; add, sub and rotate results can still set bits 7:6
      ex(op_t'(1 + $urandom % 7), ($urandom % 3) == 0, 8'($urandom), 8'($urandom),
         8'($urandom) & 8'h3F);
    end
    settle();
    exec_unit_model_inst.issue(doze_op, 0, 8'h00, 8'h00, 8'h00, 7'h00);
    exec_unit_model_inst.issue(alu_add, 0, 8'h01, 8'h01, 8'h00, 7'h00);
    settle();
    check("dozing", core_dozing, 1);
    check("doze bits", flags[4:3], 2'b10);
    ref_f[4:3] = 2'b10;
    axi_read(8'h08, 32'h7, 2'b00);
    wake_irq <= 1;
    @(posedge aclk);
    wake_irq <= 0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check("woken", core_dozing, 0);
    // external reset out of doze: bank bits cleared, cause bits kept, no supply delay
    axi_write(8'h00, 32'h20, 4'h1, 2'b00);
    exec_unit_model_inst.issue(doze_op, 0, 8'h00, 8'h00, 8'h00, 7'h00);
    exec_unit_model_inst.idle();
    ext_n <= 0;
    wait_hold(1'b1);
    @(negedge aclk);
    check("ext reset flags", flags[7:3], 5'b00010);
    @(posedge aclk);
    ext_n <= 1;
    wait_hold(1'b0);
    @(negedge aclk);
    check("ext wake", core_dozing, 0);
    @(posedge aclk);
    exec_unit_model_inst.issue(watchdog_kick_op, 0, 8'h00, 8'h00, 8'h00, 7'h00);
    settle();
    check("kick bits", flags[4:3], 2'b11);
    axi_write(8'h04, 32'h1, 4'h3, 2'b00);
    wd_en <= 1;
    wait_hold(1'b1);
    @(negedge aclk);
    check("timeout flags", flags[7:3], 5'b00001);
    // watchdog wake out of doze: back to run with the expiry bit cleared
    axi_write(8'h04, 32'h4, 4'h3, 2'b00);
    wait_hold(1'b0);
    exec_unit_model_inst.issue(doze_op, 0, 8'h00, 8'h00, 8'h00, 7'h00);
    exec_unit_model_inst.idle();
    @(negedge aclk);
    check("wd doze", core_dozing, 1);
    i = 0;
    while (core_dozing === 1'b1 && i < 40) begin
      @(negedge aclk);
      i++;
    end
    check("wd wake", {core_hold, core_dozing, flags[4]}, 3'b000);
    close_out();
  end
endmodule // cpu_status_flags_bench
